/* swmw_defs.svh */
// Timing and mode constants for the single wire master writer.
// Assumes a 200 MHz system clock; counts are derived from times in ns.
`ifndef SWMW_DEFS_SVH
`define SWMW_DEFS_SVH

`define SWMW_CLK_PERIOD_NS   5
`define SWMW_RST_LOW_NS      480000
`define SWMW_RST_SAMPLE_NS   70000
`define SWMW_RST_TOTAL_NS    960000
`define SWMW_ONE_LOW_NS      6000
`define SWMW_ZERO_LOW_NS     60000
`define SWMW_SLOT_NS         70000
`define SWMW_RST_LOW_CYC     (`SWMW_RST_LOW_NS / `SWMW_CLK_PERIOD_NS)
`define SWMW_RST_SAMPLE_CYC  (`SWMW_RST_SAMPLE_NS / `SWMW_CLK_PERIOD_NS)
`define SWMW_RST_TOTAL_CYC   (`SWMW_RST_TOTAL_NS / `SWMW_CLK_PERIOD_NS)
`define SWMW_ONE_LOW_CYC     (`SWMW_ONE_LOW_NS / `SWMW_CLK_PERIOD_NS)
`define SWMW_ZERO_LOW_CYC    (`SWMW_ZERO_LOW_NS / `SWMW_CLK_PERIOD_NS)
`define SWMW_SLOT_CYC        (`SWMW_SLOT_NS / `SWMW_CLK_PERIOD_NS)
`define SWMW_MODE_RST_BEFORE 0
`define SWMW_MODE_RST_AFTER  1
`define SWMW_MODE_BIT        2
`define SWMW_ARRAY_DEPTH     16
`define SWMW_LEN_W           5

`endif

/* swmw_pkg.sv */
// Types for the single wire master writer.
// Assumes swmw_defs.svh is on the include path.
`include "swmw_defs.svh"

package swmw_pkg;

    typedef enum logic [2:0]
    {
        SWMW_IDLE     = 3'b000,
        SWMW_RST_LOW  = 3'b001,
        SWMW_RST_WAIT = 3'b010,
        SWMW_SLOT     = 3'b011,
        SWMW_NEXT     = 3'b100,
        SWMW_DONE     = 3'b101
    } swmw_state_t;

    typedef struct packed
    {
        logic [2:0]             mode;
        logic [`SWMW_LEN_W-1:0] len;
    } swmw_cmd_t;

    typedef struct packed
    {
        logic       presence;
        logic       presence_valid;
        logic       done;
    } swmw_stat_t;

endpackage : swmw_pkg

/* swmw_slave_model.sv */
// Behavioural slave: answers resets with presence, decodes write slots.
// Assumes a pulled-up line; sym 2 = reset, 1 = one, 0 = zero.
`timescale 1ns/100ps
`default_nettype none
module swmw_slave_model
(
    input  wire logic  clk_i,
    input  wire logic  line_i,
    input  wire logic  pres_en_i,
    output logic       pull_o,
    output logic       sym_v_o,
    output logic [1:0] sym_o
);
    int unsigned lo = 0;
    int unsigned pc = 0;
    initial pull_o = 1'b0;
    always @(posedge clk_i)
    begin
        sym_v_o <= 1'b0;
        if (!line_i && !pull_o)
            lo <= lo + 1;
        else if (lo != 0)
        begin
            sym_v_o <= 1'b1;
            // Thresholds sit between the bench's one, zero and reset low times
            sym_o <= (lo >= 120) ? 2'h2 : (lo >= 30) ? 2'h0 : 2'h1;
            lo <= 0;
        end
        pc <= (lo >= 120 && line_i) ? 1 : (pc != 0 && pc < 40) ? pc + 1 : 0;
        // Only ever pulls low, never drives high
        pull_o <= pres_en_i && pc >= 2 && pc < 30;
    end
endmodule : swmw_slave_model
`default_nettype wire

/* swmw_writer.sv */
// Single wire master transmit engine with reset/presence and byte/bit modes.
// Assumes an external pull-up on the shared line and a 200 MHz clk_i.
// How it works
// RULE1 - Mode 0..7; modes 0-3 send bytes with none/before/after/both resets
// RULE2 - Modes 4-7 send single bits with the same reset placement
// RULE3 - Reset before data: pulse, sample presence, then shift data
// RULE4 - Line toggles driven/released; always released when transfer completes
// RULE5 - Bit modes send only bit 0 of each item
// RULE6 - Array elements go out in ascending index, first n or all
// RULE7 - Line is only pulled low or released, never driven high
// RULE8 - Bytes shift out least significant bit first
// RULE9 - One is short low pulse, zero long low pulse, counts configurable
`timescale 1ns/100ps
`default_nettype none
`include "swmw_defs.svh"

module swmw_writer
#(
    parameter int unsigned RST_LOW_CYC    = `SWMW_RST_LOW_CYC,
    parameter int unsigned RST_SAMPLE_CYC = `SWMW_RST_SAMPLE_CYC,
    parameter int unsigned RST_TOTAL_CYC  = `SWMW_RST_TOTAL_CYC,
    parameter int unsigned SLOT_CYC       = `SWMW_SLOT_CYC,
    parameter int unsigned ONE_LOW_CYC    = `SWMW_ONE_LOW_CYC,
    parameter int unsigned ZERO_LOW_CYC   = `SWMW_ZERO_LOW_CYC
)
(
    input  wire logic                      clk_i,
    input  wire logic                      rstn_i,
    input  wire logic                      en_i,
    input  wire logic                      start_i,
    input  wire swmw_pkg::swmw_cmd_t       cmd_i,
    input  wire logic                      wr_en_i,
    input  wire logic [`SWMW_LEN_W-2:0]    wr_idx_i,
    input  wire logic [7:0]                wr_data_i,
    input  wire logic                      line_i,
    output logic                           line_o,
    output logic                           line_oe_o,
    output logic                           busy_o,
    output swmw_pkg::swmw_stat_t           stat_o
);
    import swmw_pkg::*;

    localparam int unsigned DEPTH = `SWMW_ARRAY_DEPTH;

    logic [7:0]             mem_q [DEPTH];
    swmw_state_t            state_q,  state_d;
    logic [2:0]             mode_q,   mode_d;
    logic [`SWMW_LEN_W-1:0] len_q,    len_d;
    logic [`SWMW_LEN_W-1:0] idx_q,    idx_d;
    logic [2:0]             bit_q,    bit_d;
    logic [19:0]            cnt_q,    cnt_d;
    logic                   after_q,  after_d;
    logic                   drive_q,  drive_d;
    swmw_stat_t             stat_q,   stat_d;
    logic                   sync1_q,  sync2_q;
    logic                   cur_bit;

    // Low time of a write slot for the given bit value
    function automatic logic [19:0] low_cycles(input logic b);
        low_cycles = b ? 20'(ONE_LOW_CYC) : 20'(ZERO_LOW_CYC); // RULE9
    endfunction : low_cycles

    always_ff @(posedge clk_i)
    begin
        if (en_i && wr_en_i && !busy_o)
        begin
            mem_q[wr_idx_i] <= wr_data_i;
        end
    end

    // Line level is asynchronous to clk_i
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end
        else if (en_i)
        begin
            sync1_q <= line_i;
            sync2_q <= sync1_q;
        end
    end

    always_comb
    begin
        cur_bit = mem_q[idx_q[`SWMW_LEN_W-2:0]][bit_q];   // RULE8
        if (mode_q[`SWMW_MODE_BIT])
        begin
            cur_bit = mem_q[idx_q[`SWMW_LEN_W-2:0]][0];   // RULE5
        end
    end

    always_comb
    begin
        state_d = state_q;
        mode_d  = mode_q;
        len_d   = len_q;
        idx_d   = idx_q;
        bit_d   = bit_q;
        cnt_d   = cnt_q;
        after_d = after_q;
        drive_d = 1'b0;
        stat_d  = stat_q;
        stat_d.done = 1'b0;
        case (state_q)
            SWMW_IDLE:
            begin
                if (start_i)
                begin
                    mode_d  = cmd_i.mode;                 // RULE1 RULE2
                    // Zero length means the whole array
                    len_d   = (cmd_i.len == '0 || cmd_i.len > `SWMW_LEN_W'(DEPTH)) ?
                              `SWMW_LEN_W'(DEPTH) : cmd_i.len; // RULE6
                    idx_d   = '0;
                    bit_d   = '0;
                    cnt_d   = '0;
                    after_d = 1'b0;
                    stat_d.presence_valid = 1'b0;
                    if (cmd_i.mode[`SWMW_MODE_RST_BEFORE])
                    begin
                        state_d = SWMW_RST_LOW;           // RULE3
                        drive_d = 1'b1;
                    end
                    else
                    begin
                        state_d = SWMW_SLOT;
                        drive_d = 1'b1;
                    end
                end
            end
            SWMW_RST_LOW:
            begin
                drive_d = 1'b1;
                cnt_d   = cnt_q + 20'd1;
                if (cnt_q == 20'(RST_LOW_CYC - 1))
                begin
                    drive_d = 1'b0;                       // RULE4
                    cnt_d   = '0;
                    state_d = SWMW_RST_WAIT;
                end
            end
            SWMW_RST_WAIT:
            begin
                cnt_d = cnt_q + 20'd1;
                if (cnt_q == 20'(RST_SAMPLE_CYC - 1))
                begin
                    stat_d.presence       = ~sync2_q;     // RULE3
                    stat_d.presence_valid = 1'b1;
                end
                if (cnt_q == 20'(RST_TOTAL_CYC - RST_LOW_CYC - 1))
                begin
                    cnt_d   = '0;
                    state_d = after_q ? SWMW_DONE : SWMW_SLOT;
                    drive_d = ~after_q;
                end
            end
            SWMW_SLOT:
            begin
                cnt_d   = cnt_q + 20'd1;
                drive_d = (cnt_q + 20'd1) < low_cycles(cur_bit); // RULE9 RULE7
                if (cnt_q == 20'(SLOT_CYC - 1))
                begin
                    cnt_d   = '0;
                    drive_d = 1'b0;
                    state_d = SWMW_NEXT;
                end
            end
            SWMW_NEXT:
            begin
                // One idle cycle of release between slots for recovery
                state_d = SWMW_SLOT;
                drive_d = 1'b1;
                if (!mode_q[`SWMW_MODE_BIT] && bit_q != 3'd7)
                begin
                    bit_d = bit_q + 3'd1;                 // RULE8
                end
                else if (idx_q + `SWMW_LEN_W'(1) < len_q)
                begin
                    bit_d = '0;
                    idx_d = idx_q + `SWMW_LEN_W'(1);     // RULE6
                end
                else if (mode_q[`SWMW_MODE_RST_AFTER])
                begin
                    after_d = 1'b1;
                    state_d = SWMW_RST_LOW;              // RULE1
                end
                else
                begin
                    drive_d = 1'b0;
                    state_d = SWMW_DONE;
                end
            end
            SWMW_DONE:
            begin
                drive_d     = 1'b0;                       // RULE4
                stat_d.done = 1'b1;
                state_d     = SWMW_IDLE;
            end
            default:
            begin
                state_d = SWMW_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_q <= SWMW_IDLE;
            mode_q  <= '0;
            len_q   <= '0;
            idx_q   <= '0;
            bit_q   <= '0;
            cnt_q   <= '0;
            after_q <= 1'b0;
            drive_q <= 1'b0;
            stat_q  <= '0;
        end
        else if (en_i)
        begin
            state_q <= state_d;
            mode_q  <= mode_d;
            len_q   <= len_d;
            idx_q   <= idx_d;
            bit_q   <= bit_d;
            cnt_q   <= cnt_d;
            after_q <= after_d;
            drive_q <= drive_d;
            stat_q  <= stat_d;
        end
    end

    // Open drain: only ever pull low, enable is active low
    assign line_o    = 1'b0;                              // RULE7
    assign line_oe_o = ~drive_q;                          // RULE4
    assign busy_o    = (state_q != SWMW_IDLE);
    assign stat_o    = stat_q;

endmodule : swmw_writer
`default_nettype wire

/* swmw_writer_props.sv */
// Port checker for the single wire master writer.
// Assumes it is bound to every swmw_writer instance.
`timescale 1ns/100ps
`default_nettype none
`include "swmw_defs.svh"
module swmw_writer_props
#(
    parameter int unsigned RST_LOW_CYC  = `SWMW_RST_LOW_CYC,
    parameter int unsigned ONE_LOW_CYC  = `SWMW_ONE_LOW_CYC,
    parameter int unsigned ZERO_LOW_CYC = `SWMW_ZERO_LOW_CYC
)
(
    input wire logic                 clk_i,
    input wire logic                 rstn_i,
    input wire logic                 en_i,
    input wire logic                 start_i,
    input wire swmw_pkg::swmw_cmd_t  cmd_i,
    input wire logic                 line_o,
    input wire logic                 line_oe_o,
    input wire logic                 busy_o,
    input wire swmw_pkg::swmw_stat_t stat_o
);
    import swmw_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    wire logic  take = en_i && start_i && !busy_o;
    logic [19:0] low_q;
    logic [19:0] low_d;
    // Length of the current low run in enabled cycles; frozen cycles do not count
    always_comb low_d = line_oe_o ? 20'h0 : (en_i ? low_q + 20'h1 : low_q);
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            low_q <= 20'h0;
        else
            low_q <= low_d;
    end
    open_drain_a: assert property (line_o == 1'b0) else $error("line driven high");
    idle_release_a: assert property (!busy_o |-> line_oe_o) else $error("idle not released");
    start_busy_a: assert property (take |=> busy_o) else $error("start not taken");
    start_low_a: assert property (take |=> ##[0:1] !line_oe_o) else $error("no pulse");
    pulse_len_a: assert property ($rose(line_oe_o) |->
        low_q inside {20'(ONE_LOW_CYC), 20'(ZERO_LOW_CYC), 20'(RST_LOW_CYC)})
        else $error("bad low");
    release_hold_a: assert property ($rose(line_oe_o) |-> line_oe_o [*8]) else $error("short");
    done_pulse_a: assert property (stat_o.done |=> !stat_o.done) else $error("long done");
    pres_clear_a: assert property (take |=> !stat_o.presence_valid) else $error("stale");
    pres_hold_a: assert property (!busy_o && !take |=> $stable(stat_o.presence))
        else $error("presence moved");
    cover property (take && cmd_i.mode[2]);
    cover property (take && cmd_i.mode == 3'h1);
    cover property (stat_o.presence && stat_o.presence_valid);
    cover property (take && cmd_i.len == 5'h00);
endmodule : swmw_writer_props
bind swmw_writer swmw_writer_props #(.RST_LOW_CYC(RST_LOW_CYC), .ONE_LOW_CYC(ONE_LOW_CYC),
    .ZERO_LOW_CYC(ZERO_LOW_CYC)) i_swmw_writer_props
    (.clk_i(clk_i), .rstn_i(rstn_i), .en_i(en_i), .start_i(start_i), .cmd_i(cmd_i),
     .line_o(line_o), .line_oe_o(line_oe_o), .busy_o(busy_o), .stat_o(stat_o));
`default_nettype wire

/* swmw_writer_tb.sv */
// Bench: slave model on the line, decoded symbols checked in order.
// Assumes shortened reset counts; slot count must exceed the zero pulse.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module swmw_writer_tb;
    import swmw_pkg::*;
    logic       clk_i = 0, rstn_i = 0, en_i = 1, start_i = 0, wr_en_i = 0, pres_en = 1;
    logic [3:0] wr_idx_i = '0;
    logic [7:0] wr_data_i = '0, mem_m [16];
    logic [1:0] sym, e, exp_q[$];
    swmw_cmd_t  cmd_i = '0;
    swmw_stat_t stat_o;
    logic       line_o, line_oe_o, busy_o, pull, sym_v;
    int         n_fail = 0, num_checks = 0;
    wire logic  line = (line_oe_o | line_o) & ~pull;
    swmw_writer #(.RST_LOW_CYC(200), .RST_SAMPLE_CYC(20), .RST_TOTAL_CYC(400), .SLOT_CYC(70),
        .ONE_LOW_CYC(6), .ZERO_LOW_CYC(60))
    i_swmw_writer (.clk_i(clk_i), .rstn_i(rstn_i), .en_i(en_i), .start_i(start_i),
        .cmd_i(cmd_i), .wr_en_i(wr_en_i), .wr_idx_i(wr_idx_i), .wr_data_i(wr_data_i),
        .line_i(line), .line_o(line_o), .line_oe_o(line_oe_o), .busy_o(busy_o),
        .stat_o(stat_o));
    swmw_slave_model i_swmw_slave_model (.clk_i(clk_i), .line_i(line), .pres_en_i(pres_en),
        .pull_o(pull), .sym_v_o(sym_v), .sym_o(sym));
    initial forever #2.5 clk_i = ~clk_i;
    task automatic summarize();
        if (n_fail == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    task automatic wr(input logic [3:0] idx, input logic [7:0] v);
        @(posedge clk_i) #1 wr_idx_i = idx;
        wr_data_i = v;
        wr_en_i = 1'b1;
        @(posedge clk_i) #1 wr_en_i = 1'b0;
    endtask : wr
    task automatic run(input logic [2:0] m, input logic [4:0] len, input logic p);
        int n;
        int last;
        // Zero or oversized length sends the whole array
        last = (len == 5'h00 || len > 5'h10) ? 16 : int'(len);
        if (m[0])
            exp_q.push_back(2'h2);
        // Bit mode takes bit 0 only; bytes go out least significant first
        for (int k = 0; k < last; k++)
            for (int i = 0; i < (m[2] ? 1 : 8); i++)
                exp_q.push_back({1'b0, mem_m[k][i]});
        if (m[1])
            exp_q.push_back(2'h2);
        @(posedge clk_i) #1 cmd_i = '{mode: m, len: len};
        start_i = 1'b1;
        @(posedge clk_i) #1 start_i = 1'b0;
        for (n = 0; stat_o.done !== 1'b1 && n < 6000; n++)
            @(posedge clk_i) #1;
        `CHK(stat_o.done, 1'b1)
        `CHK(stat_o.presence, p)
        `CHK(line_oe_o, 1'b1)
        `CHK(exp_q.size() == 0, 1'b1)
    endtask : run
    always @(posedge clk_i)
    begin
        if (sym_v === 1'b1)
        begin
            e = exp_q.size() ? exp_q.pop_front() : 2'h3;
            `CHK(sym, e)
        end
    end
    initial
    begin
        // Three transfers take about 6000 cycles
        repeat (20000) @(posedge clk_i);
        n_fail++;
        summarize();
    end
    initial
    begin
        void'($urandom(32'h61d6));
        repeat (2) @(posedge clk_i);
        #1 rstn_i = 1'b1;
        for (int k = 0; k < 16; k++)
        begin
            mem_m[k] = 8'($urandom);
            wr(4'(k), mem_m[k]);
        end
        fork
            run(3'h1, 5'h03, 1'b1);
            begin
                // Write while busy must be ignored
                repeat (50) @(posedge clk_i);
                wr(4'h0, ~mem_m[0]);
                // Clock enable low freezes the reset pulse part-way
                repeat (8) @(posedge clk_i);
                #1 en_i = 1'b0;
                repeat (7) @(posedge clk_i);
                #1 en_i = 1'b1;
            end
        join
        #1 pres_en = 1'b0;
        run(3'h7, 5'h00, 1'b0);
        #1 pres_en = 1'b1;
        run(3'h2, 5'h02, 1'b1);
        summarize();
    end
endmodule : swmw_writer_tb
`default_nettype wire
